/* File: hw/atb_crc.sv */
`timescale 1ns/1ns
module atb_crc
(
   input  wire logic        sys_clk_in,
   input  wire logic        nrst_in,
   input  wire logic        ce_in,
   input  wire logic        init_in,
   input  wire logic        valid_in,
   input  wire logic [7:0]  data_in,
   output logic      [15:0] crc_out
);
   import atb_pkg::*;

   logic [15:0] crc_reg;
   logic [15:0] crc_next;

   // lsb-first bytewise update, register is kept uncomplemented
   always_comb
   begin
      crc_next = crc_reg;
      for (int i = 0; i < 8; i++)
      begin
         if (crc_next[0] ^ data_in[i])
            crc_next = (crc_next >> 1) ^ CRC_POLY;
         else
            crc_next = crc_next >> 1;
      end
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (!nrst_in)
         crc_reg <= CRC_INIT;
      else if (ce_in)
      begin
         if (init_in)
            crc_reg <= CRC_INIT;
         else if (valid_in)
            crc_reg <= crc_next;
      end
   end

   assign crc_out = crc_reg;

endmodule : atb_crc

/* File: hw/atb_handler.sv */
`timescale 1ns/1ns
// Notes on behaviour
// - a valid frame moves the tag from selected into the command-ready state.
// - frame is code 1D, four identifier bytes, four parameters, two crc bytes.
// - tag always uses tr0 64/fs, tr1 80/fs, never omits sof/eof, ignores bits 1-0.
// - reserved 11b in the tr0 or tr1 fields is read as 00b.
// - param2 rates 106 or 212 kbps each; differing rates get no answer.
// - unsupported rate or frame size code in param2 gets no answer.
// - param3 must be 01h, protocol type of the atqb; else no answer.
// - param4 bits 7-4 ignored; answer only when bits 3-0 are zero.
// - answer is one byte 10h followed by crc_b.
module atb_handler
(
   input  wire logic               sys_clk_in,
   input  wire logic               nrst_in,
   input  wire logic               ce_in,
   input  wire logic               selected_in,
   input  wire logic               deactivate_in,
   input  wire logic [31:0]        pupi_in,
   input  wire logic               rx_valid_in,
   input  wire logic [7:0]         rx_byte_in,
   input  wire logic               rx_end_in,
   input  wire logic               tx_ready_in,
   output logic                    tx_valid_out,
   output logic      [7:0]         tx_byte_out,
   output logic                    tx_last_out,
   output logic                    active_out,
   output logic                    accept_out,
   output atb_pkg::atb_link_s      link_out,
   output logic      [7:0]         tr0_fs_out,
   output logic      [7:0]         tr1_fs_out,
   output logic                    omit_sof_out,
   output logic                    omit_eof_out
);
   import atb_pkg::*;

   atb_state_e  state_reg;
   logic [3:0]  idx_reg;
   logic        bad_reg;
   logic        long_reg;
   atb_link_s   req_reg;
   logic [15:0] rx_crc;
   logic [15:0] tx_crc;
   logic        frame_ok;
   logic        rx_take;
   logic        byte_bad;
   logic        tx_step;
   logic [7:0]  pupi_byte;

   ////////////////////////////////////////////////////////////////////////////
   // receive side: fields are checked as they fly past, nothing is buffered
   // bytes are ignored while an answer is still going out
   assign rx_take = ce_in && rx_valid_in && state_reg == ST_RX;

   // identifier arrives msb first; indices outside the id shift the word out to zero
   assign pupi_byte = 8'(pupi_in >> {IDX_ID3 - idx_reg, 3'b000});

   always_comb
   begin
      byte_bad = 1'b0;
      if (idx_reg == IDX_CMD)
         byte_bad = rx_byte_in != CMD_ATTRIB;
      else if (idx_reg >= IDX_ID0 && idx_reg <= IDX_ID3)
         byte_bad = rx_byte_in != pupi_byte;
      else if (idx_reg == IDX_P2)
         byte_bad = !(rx_byte_in[3:0] inside {FSZ_256, FSZ_128, FSZ_96, FSZ_64})
                    || !(rx_byte_in[7:6] inside {RATE_106, RATE_212})
                    || rx_byte_in[7:6] != rx_byte_in[5:4];
      else if (idx_reg == IDX_P3)
         byte_bad = rx_byte_in != PARAM3_OK;
      else if (idx_reg == IDX_P4)
         byte_bad = rx_byte_in[3:0] != CID_NONE;
   end

   always_ff @(posedge sys_clk_in)
   begin
      // the closing strobe restarts the frame exactly as reset does
      if (!nrst_in || (ce_in && rx_end_in))
      begin
         idx_reg  <= 4'h0;
         bad_reg  <= 1'b0;
         long_reg <= 1'b0;
      end
      else if (rx_take)
      begin
         if (idx_reg == FRAME_LEN)
            long_reg <= 1'b1;
         else
            idx_reg <= idx_reg + 4'h1;
         if (byte_bad)
            bad_reg <= 1'b1;
      end
   end

   // requested link settings, kept for visibility only
   always_ff @(posedge sys_clk_in)
   begin
      if (!nrst_in)
      begin
         req_reg  <= '0;
      end
      else if (rx_take && idx_reg == IDX_P1)
      begin
         // reserved delay code falls back to the default; bits 1-0 dropped
         req_reg.tr0_req      <= rx_byte_in[7:6] == TR_RESERVED ? TR_DEFAULT
                                                                 : rx_byte_in[7:6];
         req_reg.tr1_req      <= rx_byte_in[5:4] == TR_RESERVED ? TR_DEFAULT
                                                                 : rx_byte_in[5:4];
         req_reg.eof_omit_req <= rx_byte_in[3];
         req_reg.sof_omit_req <= rx_byte_in[2];
      end
      else if (rx_take && idx_reg == IDX_P2)
      begin
         req_reg.frame_size  <= rx_byte_in[3:0];
         req_reg.rate_212    <= rx_byte_in[7:6] == RATE_212;
      end
   end

   atb_crc u_rx_crc
   (
      .sys_clk_in (sys_clk_in),
      .nrst_in    (nrst_in),
      .ce_in      (ce_in),
      .init_in    (rx_end_in),
      .valid_in   (rx_take),
      .data_in    (rx_byte_in),
      .crc_out    (rx_crc)
   );

   // a short or long frame, a wrong field or a bad crc all end in silence
   assign frame_ok = ce_in && rx_end_in && state_reg == ST_RX && selected_in && !active_out
                     && idx_reg == FRAME_LEN && !long_reg && !bad_reg
                     && rx_crc == CRC_RESIDUE;

   ////////////////////////////////////////////////////////////////////////////
   // answer side
   assign tx_step = ce_in && tx_valid_out && tx_ready_in;

   always_ff @(posedge sys_clk_in)
   begin
      if (!nrst_in)
         state_reg <= ST_RX;
      else if (ce_in)
      begin
         unique case (state_reg)
            ST_RX:     if (frame_ok) state_reg <= ST_TX_ANS;
            ST_TX_ANS: if (tx_step)  state_reg <= ST_TX_CLO;
            ST_TX_CLO: if (tx_step)  state_reg <= ST_TX_CHI;
            ST_TX_CHI: if (tx_step)  state_reg <= ST_RX;
         endcase
      end
   end

   atb_crc u_tx_crc
   (
      .sys_clk_in (sys_clk_in),
      .nrst_in    (nrst_in),
      .ce_in      (ce_in),
      .init_in    (frame_ok),
      .valid_in   (tx_step && state_reg == ST_TX_ANS),
      .data_in    (tx_byte_out),
      .crc_out    (tx_crc)
   );

   always_ff @(posedge sys_clk_in)
   begin
      if (!nrst_in)
      begin
         tx_valid_out <= 1'b0;
         tx_byte_out  <= 8'h00;
         tx_last_out  <= 1'b0;
      end
      else if (ce_in)
      begin
         if (frame_ok)
         begin
            tx_valid_out <= 1'b1;
            tx_byte_out  <= ANSWER_CODE;
            tx_last_out  <= 1'b0;
         end
         else if (tx_step)
         begin
            unique case (state_reg)
               ST_TX_ANS:
               begin
                  // the crc unit takes the code byte at this edge, so lo waits one cycle
                  tx_byte_out <= 8'h00;
                  tx_valid_out <= 1'b0;
               end
               ST_TX_CLO:
               begin
                  tx_byte_out <= ~tx_crc[15:8];
                  tx_last_out <= 1'b1;
               end
               ST_TX_CHI:
               begin
                  tx_valid_out <= 1'b0;
                  tx_last_out  <= 1'b0;
               end
               ST_RX:
               begin
                  tx_valid_out <= 1'b0;
               end
            endcase
         end
         else if (state_reg == ST_TX_CLO && !tx_valid_out)
         begin
            tx_valid_out <= 1'b1;
            tx_byte_out  <= ~tx_crc[7:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // tag state and the link settings the reader asked for
   always_ff @(posedge sys_clk_in)
   begin
      if (!nrst_in)
      begin
         active_out <= 1'b0;
         accept_out <= 1'b0;
         link_out   <= '0;
      end
      else if (ce_in)
      begin
         accept_out <= frame_ok;
         if (frame_ok)
         begin
            active_out <= 1'b1;
            link_out   <= req_reg;
         end
         else if (deactivate_in)
            active_out <= 1'b0;
      end
   end

   // fixed timing whatever the reader asked for; the values never move, so ce has nothing to hold
   always_ff @(posedge sys_clk_in)
   begin
      tr0_fs_out   <= TR0_MIN_FS;
      tr1_fs_out   <= TR1_MIN_FS;
      omit_sof_out <= 1'b0;
      omit_eof_out <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!nrst_in);

   sequence s_accept;
      frame_ok;
   endsequence

   sequence s_answer_up;
      accept_out && active_out && tx_valid_out && tx_byte_out == ANSWER_CODE;
   endsequence

   AST_ACTIVATE: assert property (s_accept |=> s_answer_up)
      else $error("accepted frame did not activate and answer");
   AST_STAY: assert property ((!frame_ok && !deactivate_in && ce_in) |=>
                              active_out == $past(active_out))
      else $error("tag state changed without an accepted frame");
   AST_CMD: assert property (rx_take && !rx_end_in && idx_reg == IDX_CMD
                             && rx_byte_in != CMD_ATTRIB |=> bad_reg)
      else $error("wrong command code not refused");
   AST_RATE: assert property (rx_take && idx_reg == IDX_P2
                              && rx_byte_in[7:6] != rx_byte_in[5:4] |=> bad_reg)
      else $error("differing rates not refused");
   AST_FSIZE: assert property (rx_take && idx_reg == IDX_P2 && rx_byte_in[3:0] == 4'h4
                               |=> bad_reg)
      else $error("unsupported frame size not refused");
   AST_PARAM3: assert property (rx_take && idx_reg == IDX_P3 && rx_byte_in != PARAM3_OK
                                |=> bad_reg)
      else $error("wrong protocol type not refused");
   AST_CID: assert property (rx_take && idx_reg == IDX_P4 && rx_byte_in[3:0] != CID_NONE
                             |=> bad_reg)
      else $error("cid request not refused");
   AST_CRC: assert property (rx_end_in && rx_crc != CRC_RESIDUE |=> !accept_out)
      else $error("frame with bad crc was accepted");
   AST_TIMING: assert property (tr0_fs_out == TR0_MIN_FS && tr1_fs_out == TR1_MIN_FS
                                && !omit_sof_out && !omit_eof_out)
      else $error("response timing not fixed");
   AST_RSV: assert property (rx_take && idx_reg == IDX_P1 && rx_byte_in[7:6] == TR_RESERVED
                             |=> req_reg.tr0_req == TR_DEFAULT)
      else $error("reserved tr0 code not defaulted");
   AST_FRAME: assert property (s_accept ##1 (tx_ready_in && ce_in)[*4]
                               |=> !tx_valid_out && state_reg == ST_RX)
      else $error("answer not finished with ready held high");

endmodule : atb_handler

/* File: hw/atb_pkg.sv */
package atb_pkg;

   localparam logic [7:0]  CMD_ATTRIB     = 8'h1D;
   localparam logic [7:0]  ANSWER_CODE    = 8'h10;   // buffer length 1 frame, no cid
   localparam logic [3:0]  PROTO_TYPE     = 4'h1;
   localparam logic [7:0]  PARAM3_OK      = {4'h0, PROTO_TYPE};
   localparam logic [3:0]  CID_NONE       = 4'h0;
   localparam logic [1:0]  RATE_106       = 2'h0;
   localparam logic [1:0]  RATE_212       = 2'h1;
   localparam logic [3:0]  FSZ_256        = 4'h8;
   localparam logic [3:0]  FSZ_128        = 4'h7;
   localparam logic [3:0]  FSZ_96         = 4'h6;
   localparam logic [3:0]  FSZ_64         = 4'h5;
   localparam logic [1:0]  TR_RESERVED    = 2'h3;
   localparam logic [1:0]  TR_DEFAULT     = 2'h0;
   localparam logic [7:0]  TR0_MIN_FS     = 8'h40;   // 64/fs
   localparam logic [7:0]  TR1_MIN_FS     = 8'h50;   // 80/fs

   // byte positions inside the command frame
   localparam logic [3:0]  IDX_CMD        = 4'h0;
   localparam logic [3:0]  IDX_ID0        = 4'h1;
   localparam logic [3:0]  IDX_ID3        = 4'h4;
   localparam logic [3:0]  IDX_P1         = 4'h5;
   localparam logic [3:0]  IDX_P2         = 4'h6;
   localparam logic [3:0]  IDX_P3         = 4'h7;
   localparam logic [3:0]  IDX_P4         = 4'h8;
   localparam logic [3:0]  FRAME_LEN      = 4'hB;

   localparam logic [15:0] CRC_INIT       = 16'hFFFF;
   localparam logic [15:0] CRC_POLY       = 16'h8408;
   localparam logic [15:0] CRC_RESIDUE    = 16'hF0B8;

   typedef struct packed {
      logic [1:0] tr0_req;
      logic [1:0] tr1_req;
      logic       eof_omit_req;
      logic       sof_omit_req;
      logic       rate_212;
      logic [3:0] frame_size;
   } atb_link_s;

   typedef enum logic [1:0] {
      ST_RX     = 2'b00,
      ST_TX_ANS = 2'b01,
      ST_TX_CLO = 2'b10,
      ST_TX_CHI = 2'b11
   } atb_state_e;

endpackage : atb_pkg

/* File: sim/atb_handler_tb.sv */
`timescale 1ns/1ns
module atb_handler_tb;
   import atb_pkg::*;
   localparam logic [31:0] PUPI = 32'hA5C35A3C;
   logic        sys_clk_in, nrst_in, selected_in, deactivate_in, slow, ce;
   logic        rx_valid, rx_end, tx_ready, tx_valid, tx_last, active, accept;
   logic [7:0]  rx_byte, tx_byte, tr0_fs, tr1_fs;
   logic        omit_sof, omit_eof;
   atb_link_s   link;
   int          mismatches, tests_run, acc_cnt, cycles;

   atb_handler dut (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .ce_in(ce),
      .selected_in(selected_in), .deactivate_in(deactivate_in), .pupi_in(PUPI),
      .rx_valid_in(rx_valid), .rx_byte_in(rx_byte), .rx_end_in(rx_end),
      .tx_ready_in(tx_ready), .tx_valid_out(tx_valid), .tx_byte_out(tx_byte),
      .tx_last_out(tx_last), .active_out(active), .accept_out(accept),
      .link_out(link), .tr0_fs_out(tr0_fs), .tr1_fs_out(tr1_fs),
      .omit_sof_out(omit_sof), .omit_eof_out(omit_eof));
   atb_reader rd (.clk_in(sys_clk_in), .slow_in(slow), .tx_valid_in(tx_valid),
      .tx_byte_in(tx_byte), .tx_last_in(tx_last), .rx_valid_out(rx_valid),
      .rx_byte_out(rx_byte), .rx_end_out(rx_end), .tx_ready_out(tx_ready));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp)
      begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask : check

   task automatic end_sim;
      $display("mismatches %0d tests_run %0d", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_sim

   function automatic logic [71:0] pl(input logic [7:0] cmd, input logic [31:0] id,
      input logic [7:0] p1, input logic [7:0] p2, input logic [7:0] p3, input logic [7:0] p4);
      return {cmd, id, p1, p2, p3, p4};
   endfunction : pl

   // one frame; counts cycles with accept high, so a two-cycle pulse also shows up
   task automatic attempt(input string nm, input logic [71:0] p, input logic bad, input logic ok);
      int a0;
      logic [15:0] c;
      a0 = acc_cnt;
      rd.send(p, bad);
      repeat (3) @(posedge sys_clk_in);
      check(nm, {15'h0000, ok}, acc_cnt - a0);
      for (int i = 0; i < 40 && rd.ans_q.size() < 3; i++)
         @(posedge sys_clk_in);
      check("answer count", ok ? 16'h0003 : 16'h0000, rd.ans_q.size());
      if (ok && rd.ans_q.size() == 3)
      begin
         c = ~rd.crc_step(CRC_INIT, 8'h10);
         check("answer code", 16'h0010, rd.ans_q[0]);
         check("answer crc lo", {8'h00, c[7:0]}, rd.ans_q[1]);
         check("answer crc hi", {8'h01, c[15:8]}, rd.ans_q[2]);
      end
      rd.ans_q.delete();
   endtask : attempt

   task automatic drop;
      @(posedge sys_clk_in);
      deactivate_in <= 1'b1;
      @(posedge sys_clk_in);
      deactivate_in <= 1'b0;
      @(posedge sys_clk_in);
   endtask : drop

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_accept;
      check("tr0 at reset", 16'h0040, tr0_fs);
      check("tr1 at reset", 16'h0050, tr1_fs);
      // reserved tr codes, sof/eof omission asked, rfu bits set, both rates 212
      attempt("accept", pl(CMD_ATTRIB, PUPI, 8'hFF, 8'h58, 8'h01, 8'hF0), 1'b0, 1'b1);
      check("active", 16'h0001, active);
      check("link", {5'h00, 2'b00, 2'b00, 1'b1, 1'b1, 1'b1, 4'h8}, link);
      check("tr0 fixed", 16'h0040, tr0_fs);
      check("tr1 fixed", 16'h0050, tr1_fs);
      check("omit", 16'h0000, {omit_sof, omit_eof});
      attempt("again active", pl(CMD_ATTRIB, PUPI, 8'h00, 8'h08, 8'h01, 8'h00), 1'b0, 1'b0);
      drop();
      check("dropped", 16'h0000, active);
   endtask : t_accept

   // every accepted frame size code, stalling reader, tr requests recorded as sent
   task automatic t_sizes;
      slow <= 1'b1;
      for (int f = 5; f <= 8; f++)
      begin
         attempt("size", pl(CMD_ATTRIB, PUPI, 8'h60, f[7:0], 8'h01, 8'h00), 1'b0, 1'b1);
         check("link size", {5'h00, 2'b01, 2'b10, 3'b000, f[3:0]}, link);
         drop();
      end
      slow <= 1'b0;
   endtask : t_sizes

   task automatic t_refuse;
      logic [71:0] bad [9];
      bad = '{pl(CMD_ATTRIB, ~PUPI, 8'h00, 8'h08, 8'h01, 8'h00),
              pl(8'h1E, PUPI, 8'h00, 8'h08, 8'h01, 8'h00),
              pl(CMD_ATTRIB, PUPI, 8'h00, 8'h48, 8'h01, 8'h00),
              pl(CMD_ATTRIB, PUPI, 8'h00, 8'hA8, 8'h01, 8'h00),
              pl(CMD_ATTRIB, PUPI, 8'h00, 8'h04, 8'h01, 8'h00),
              pl(CMD_ATTRIB, PUPI, 8'h00, 8'h09, 8'h01, 8'h00),
              pl(CMD_ATTRIB, PUPI, 8'h00, 8'h08, 8'h02, 8'h00),
              pl(CMD_ATTRIB, PUPI, 8'h00, 8'h08, 8'h11, 8'h00),
              pl(CMD_ATTRIB, PUPI, 8'h00, 8'h08, 8'h01, 8'h01)};
      foreach (bad[i])
      begin
         attempt("refused", bad[i], 1'b0, 1'b0);
         check("still idle", 16'h0000, active);
      end
      attempt("bad crc", pl(CMD_ATTRIB, PUPI, 8'h00, 8'h08, 8'h01, 8'h00), 1'b1, 1'b0);
      selected_in <= 1'b0;
      attempt("not selected", pl(CMD_ATTRIB, PUPI, 8'h00, 8'h08, 8'h01, 8'h00), 1'b0, 1'b0);
      selected_in <= 1'b1;
      attempt("after refusals", pl(CMD_ATTRIB, PUPI, 8'h00, 8'h08, 8'h01, 8'h00), 1'b0, 1'b1);
      check("active", 16'h0001, active);
   endtask : t_refuse

   // a frame sent while the enable is low must leave no trace
   task automatic t_freeze;
      drop();
      ce <= 1'b0;
      attempt("frozen", pl(CMD_ATTRIB, PUPI, 8'h00, 8'h08, 8'h01, 8'h00), 1'b0, 1'b0);
      check("frozen idle", 16'h0000, active);
      ce <= 1'b1;
      attempt("thawed", pl(CMD_ATTRIB, PUPI, 8'h00, 8'h08, 8'h01, 8'h00), 1'b0, 1'b1);
      check("thawed active", 16'h0001, active);
   endtask : t_freeze

   // reset in mid-run clears the tag state, then a fresh frame is taken
   task automatic t_reset;
      nrst_in <= 1'b0;
      repeat (2) @(posedge sys_clk_in);
      check("active in reset", 16'h0000, active);
      check("tr0 in reset", 16'h0040, tr0_fs);
      nrst_in <= 1'b1;
      attempt("after reset", pl(CMD_ATTRIB, PUPI, 8'h00, 8'h08, 8'h01, 8'h00), 1'b0, 1'b1);
      check("active after reset", 16'h0001, active);
   endtask : t_reset

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      sys_clk_in = 1'b0;
      forever #5 sys_clk_in = ~sys_clk_in;
   end

   // the whole run needs about 900 cycles
   always @(posedge sys_clk_in)
   begin
      cycles++;
      if (accept === 1'b1)
         acc_cnt++;
      if (cycles == 20000)
      begin
         mismatches++;
         end_sim();
      end
   end

   initial
   begin
      nrst_in = 1'b0;
      selected_in = 1'b1;
      deactivate_in = 1'b0;
      slow = 1'b0;
      ce = 1'b1;
      repeat (6) @(posedge sys_clk_in);
      nrst_in <= 1'b1;
      @(posedge sys_clk_in);
      t_accept();
      t_sizes();
      t_refuse();
      t_freeze();
      t_reset();
      end_sim();
   end
endmodule : atb_handler_tb

/* File: sim/atb_reader.sv */
`timescale 1ns/1ns
module atb_reader
   import atb_pkg::*;
(
   input  wire logic       clk_in,
   input  wire logic       slow_in,
   input  wire logic       tx_valid_in,
   input  wire logic [7:0] tx_byte_in,
   input  wire logic       tx_last_in,
   output logic            rx_valid_out,
   output logic      [7:0] rx_byte_out,
   output logic            rx_end_out,
   output logic            tx_ready_out
);
   // answer bytes as {last, byte}, taken in order
   logic [8:0] ans_q [$];

   initial
   begin
      rx_valid_out = 1'b0;
      rx_byte_out  = 8'h00;
      rx_end_out   = 1'b0;
      tx_ready_out = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c ^ {8'h00, b};
      for (int i = 0; i < 8; i++)
         r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      return r;
   endfunction : crc_step

   // payload byte 0 in [71:64]; crc sent lsb first, bad_crc spoils it on purpose
   task automatic send(input logic [71:0] pl, input logic bad_crc);
      logic [15:0] c;
      logic [87:0] fr;
      c = CRC_INIT;
      for (int i = 8; i >= 0; i--)
         c = crc_step(c, pl[i*8 +: 8]);
      c = ~c ^ {15'h0000, bad_crc};
      fr = {pl, c[7:0], c[15:8]};
      for (int i = 10; i >= 0; i--)
      begin
         @(posedge clk_in);
         rx_valid_out <= 1'b1;
         rx_byte_out  <= fr[i*8 +: 8];
      end
      @(posedge clk_in);
      rx_valid_out <= 1'b0;
      // line released: never leave the last byte showing
      rx_byte_out  <= ~rx_byte_out;
      rx_end_out   <= 1'b1;
      @(posedge clk_in);
      rx_end_out   <= 1'b0;
   endtask : send

   ////////////////////////////////////////////////////////////////////////////////
   // slow mode stalls every other cycle so held bytes get exercised
   always @(posedge clk_in)
   begin
      if (tx_valid_in && tx_ready_out)
         ans_q.push_back({tx_last_in, tx_byte_in});
      tx_ready_out <= slow_in ? ~tx_ready_out : 1'b1;
   end
endmodule : atb_reader
